// file: core/msfc_defines.svh
/*
 * register offsets, field positions and reset values of the two
 * special function setup registers. assumes 8-bit register addressing.
 */
`ifndef MSFC_DEFINES_SVH
`define MSFC_DEFINES_SVH

`define MSFC_SFC1_ADDR      8'hbc
`define MSFC_SFC2_ADDR      8'hbd
`define MSFC_SFC1_RESET     8'h00
`define MSFC_SFC2_RESET     8'h00
`define MSFC_SFC1_WMASK     8'h7f
`define MSFC_SFC2_WMASK     8'h3f

`define MSFC_VH_LSB         0
`define MSFC_VH_MSB         2
`define MSFC_Z1_LIM_BIT     3
`define MSFC_Z2_LIM_BIT     4
`define MSFC_Z1_FAN_BIT     5
`define MSFC_Z2_FAN_BIT     6

`define MSFC_TACH_LSB       0
`define MSFC_TACH_MSB       3
`define MSFC_AB_HALF_BIT    4
`define MSFC_CD_HALF_BIT    5

`define MSFC_LIMIT_MASK     8'hff
`define MSFC_NUM_VCHAN      16

`endif

// file: core/msfc_pkg.sv
/*
 * types of the special function control block.
 * assumes msfc_defines.svh for the constants.
 */
`include "msfc_defines.svh"

package msfc_pkg;

	typedef logic [7:0] msfc_byte_t;

	typedef struct packed {
		logic out;
		logic err_set;
	} msfc_vchan_s;

	typedef struct packed {
		msfc_byte_t sfc1;
		msfc_byte_t sfc2;
		msfc_byte_t rdata;
		msfc_byte_t z1_lim;
		msfc_byte_t z2_lim;
		msfc_byte_t z1_fan;
		msfc_byte_t z2_fan;
	} msfc_top_s;

endpackage : msfc_pkg

// file: core/msfc_vchan.sv
/*
 * one voltage channel window comparator with hysteresis.
 * assumes one-cycle sample strobes synchronous to mclk.
 */
`timescale 1ns/1ns
`include "msfc_defines.svh"

module msfc_vchan
	import msfc_pkg::*;
(
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst_n,
	// sample
	input  wire logic       sample_valid,
	input  wire logic [7:0] reading,
	input  wire logic [7:0] low_limit,
	input  wire logic [7:0] high_limit,
	input  wire logic [2:0] hysteresis,
	// status
	output logic            out_of_limit,
	output logic            err_set
);
	msfc_vchan_s st_r;
	msfc_vchan_s st_nxt;
	logic [8:0]  rd_plus_h;
	logic [8:0]  low_plus_h;
	logic        masked;
	logic        enter;
	logic        back_in;

	// hysteresis counts are raw converter counts
	assign rd_plus_h  = {1'b0, reading} + {6'h00, hysteresis};
	assign low_plus_h = {1'b0, low_limit} + {6'h00, hysteresis};
	assign masked     = (high_limit == `MSFC_LIMIT_MASK);
	assign enter      = (reading > high_limit) || (reading < low_limit);
	// same hysteresis on both limits
	assign back_in    = (rd_plus_h <= {1'b0, high_limit}) && ({1'b0, reading} >= low_plus_h);

	always_comb begin
		st_nxt         = st_r;
		st_nxt.err_set = 1'b0;
		if (sample_valid) begin
			if (masked) begin
				st_nxt.out = 1'b0;
			end else begin
				st_nxt.out     = enter || (st_r.out && !back_in);
				st_nxt.err_set = enter || (st_r.out && !back_in);
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign out_of_limit = st_r.out;
	assign err_set      = st_r.err_set;

	a_err_on_excursion: assert property (@(posedge mclk) disable iff (!rst_n)
		sample_valid && !masked && enter |=> err_set && out_of_limit)
		else $error("excursion did not raise the error");
	a_hyst_holds_out: assert property (@(posedge mclk) disable iff (!rst_n)
		sample_valid && !masked && out_of_limit && (rd_plus_h > {1'b0, high_limit}) |=> out_of_limit)
		else $error("channel released inside hysteresis band");
	a_hyst_release: assert property (@(posedge mclk) disable iff (!rst_n)
		sample_valid && !masked && !enter && back_in |=> !out_of_limit ##0 !err_set)
		else $error("channel not released past hysteresis");
	a_mask_silent: assert property (@(posedge mclk) disable iff (!rst_n)
		sample_valid && masked |=> !err_set)
		else $error("masked channel raised an error");
endmodule : msfc_vchan

// file: core/msfc_top.sv
/*
 * special function setup registers of the hardware monitor and the logic
 * they steer. assumes the serial management engine presents register
 * accesses as one-cycle strobes, and the converter presents voltage samples
 * with their limits, all synchronous to mclk.
 */
// Overview of operation
// - The three-bit hysteresis value applies to every voltage limit check, high and low alike.
// - One hysteresis unit is one converter count, whatever voltage that means on a channel.
// - Zone 1 limit checks use the smoothed temperature when its limit filter select is set.
// - Zone 2 limit checks use the smoothed temperature when its limit filter select is set.
// - Zone 1 fan control, boost included, uses the smoothed temperature when its fan select is set.
// - Zone 2 fan control, boost included, uses the smoothed temperature when its fan select is set.
// - Bits zero to three each enable smart tach mode for tach inputs one to four.
// - Bit four sets half-degree fan resolution for zones one and two, bit five for zones three and four.
// - A voltage above its high limit or below its low limit sets that channel's error bits, unless a high limit of ff masks the channel.
`timescale 1ns/1ns
`include "msfc_defines.svh"

module msfc_top
	import msfc_pkg::*;
(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst_n,
	// register access
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// voltage samples
	input  wire logic        volt_valid,
	input  wire logic [3:0]  volt_chan,
	input  wire logic [7:0]  volt_reading,
	input  wire logic [7:0]  volt_low_limit,
	input  wire logic [7:0]  volt_high_limit,
	// voltage status
	output logic      [15:0] volt_out_of_limit,
	output logic      [15:0] volt_err_set,
	// zone temperatures
	input  wire logic [7:0]  zone1_raw_temp,
	input  wire logic [7:0]  zone1_smooth_temp,
	input  wire logic [7:0]  zone2_raw_temp,
	input  wire logic [7:0]  zone2_smooth_temp,
	output logic      [7:0]  zone1_limit_temp,
	output logic      [7:0]  zone2_limit_temp,
	output logic      [7:0]  zone1_fan_temp,
	output logic      [7:0]  zone2_fan_temp,
	// fan and tach configuration
	output logic      [3:0]  tach_smart_mode_enable,
	output logic             zones_a_b_half_degree_select,
	output logic             zones_c_d_half_degree_select
);
	msfc_top_s  st_r;
	msfc_top_s  st_nxt;
	logic [2:0] voltage_hysteresis_field;
	logic       zone1_limit_filter_select;
	logic       zone2_limit_filter_select;
	logic       zone1_fan_filter_select;
	logic       zone2_fan_filter_select;

	assign voltage_hysteresis_field  = st_r.sfc1[`MSFC_VH_MSB:`MSFC_VH_LSB];
	assign zone1_limit_filter_select = st_r.sfc1[`MSFC_Z1_LIM_BIT];
	assign zone2_limit_filter_select = st_r.sfc1[`MSFC_Z2_LIM_BIT];
	assign zone1_fan_filter_select   = st_r.sfc1[`MSFC_Z1_FAN_BIT];
	assign zone2_fan_filter_select   = st_r.sfc1[`MSFC_Z2_FAN_BIT];

	always_comb begin
		st_nxt = st_r;
		// writes; reserved bits stay zero
		if (reg_wr && (reg_addr == `MSFC_SFC1_ADDR)) begin
			st_nxt.sfc1 = reg_wdata & `MSFC_SFC1_WMASK;
		end
		if (reg_wr && (reg_addr == `MSFC_SFC2_ADDR)) begin
			st_nxt.sfc2 = reg_wdata & `MSFC_SFC2_WMASK;
		end
		// reads; unmapped addresses return zero
		if (reg_rd) begin
			unique case (reg_addr)
				`MSFC_SFC1_ADDR: st_nxt.rdata = st_r.sfc1;
				`MSFC_SFC2_ADDR: st_nxt.rdata = st_r.sfc2;
				default:         st_nxt.rdata = 8'h00;
			endcase
		end
		// filtered or raw temperature per zone and use
		st_nxt.z1_lim = zone1_limit_filter_select ? zone1_smooth_temp : zone1_raw_temp;
		st_nxt.z2_lim = zone2_limit_filter_select ? zone2_smooth_temp : zone2_raw_temp;
		st_nxt.z1_fan = zone1_fan_filter_select ? zone1_smooth_temp : zone1_raw_temp;
		st_nxt.z2_fan = zone2_fan_filter_select ? zone2_smooth_temp : zone2_raw_temp;
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st_r      <= '0;
			st_r.sfc1 <= `MSFC_SFC1_RESET;
			st_r.sfc2 <= `MSFC_SFC2_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata                    = st_r.rdata;
	assign zone1_limit_temp             = st_r.z1_lim;
	assign zone2_limit_temp             = st_r.z2_lim;
	assign zone1_fan_temp               = st_r.z1_fan;
	assign zone2_fan_temp               = st_r.z2_fan;
	assign tach_smart_mode_enable       = st_r.sfc2[`MSFC_TACH_MSB:`MSFC_TACH_LSB];
	assign zones_a_b_half_degree_select = st_r.sfc2[`MSFC_AB_HALF_BIT];
	assign zones_c_d_half_degree_select = st_r.sfc2[`MSFC_CD_HALF_BIT];

	// one comparator per voltage channel, all sharing the hysteresis
	genvar gi;
	generate
		for (gi = 0; gi < `MSFC_NUM_VCHAN; gi++) begin : g_vchan
			msfc_vchan u_vchan (
				.mclk         (mclk),
				.rst_n        (rst_n),
				.sample_valid (volt_valid && (volt_chan == 4'(gi))),
				.reading      (volt_reading),
				.low_limit    (volt_low_limit),
				.high_limit   (volt_high_limit),
				.hysteresis   (voltage_hysteresis_field),
				.out_of_limit (volt_out_of_limit[gi]),
				.err_set      (volt_err_set[gi])
			);
		end
	endgenerate

	a_zone1_limit_mux: assert property (@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> zone1_limit_temp == ($past(zone1_limit_filter_select) ? $past(zone1_smooth_temp)
			: $past(zone1_raw_temp)))
		else $error("zone 1 limit temperature source wrong");
	a_zone2_limit_mux: assert property (@(posedge mclk) disable iff (!rst_n)
		1'b1 |=> zone2_limit_temp == ($past(zone2_limit_filter_select) ? $past(zone2_smooth_temp)
			: $past(zone2_raw_temp)))
		else $error("zone 2 limit temperature source wrong");
	a_zone1_fan_mux: assert property (@(posedge mclk) disable iff (!rst_n)
		zone1_fan_filter_select && $stable(zone1_fan_filter_select) |=> zone1_fan_temp == $past(zone1_smooth_temp))
		else $error("zone 1 fan temperature not smoothed");
	a_zone2_fan_mux: assert property (@(posedge mclk) disable iff (!rst_n)
		!zone2_fan_filter_select && $stable(zone2_fan_filter_select) |=> zone2_fan_temp == $past(zone2_raw_temp))
		else $error("zone 2 fan temperature not raw");
	a_tach_enable_write: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == `MSFC_SFC2_ADDR |=> tach_smart_mode_enable == $past(reg_wdata[3:0]))
		else $error("smart tach enables not written");
	a_half_degree_write: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == `MSFC_SFC2_ADDR |=> {zones_c_d_half_degree_select, zones_a_b_half_degree_select}
			== $past(reg_wdata[5:4]))
		else $error("half degree selects not written");
	a_hyst_readback: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == `MSFC_SFC1_ADDR ##1 reg_rd && reg_addr == `MSFC_SFC1_ADDR && !reg_wr
			|=> reg_rdata[2:0] == $past(reg_wdata[2:0], 2) && !reg_rdata[7])
		else $error("hysteresis readback wrong");
	a_volt_err_latency: assert property (@(posedge mclk) disable iff (!rst_n)
		!volt_valid |=> volt_err_set == 16'h0000)
		else $error("error set without a sample");

	// register map
	a_hyst_write: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == `MSFC_SFC1_ADDR |=> voltage_hysteresis_field == $past(reg_wdata[2:0]))
		else $error("hysteresis field not written");
	a_filter_write: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == `MSFC_SFC1_ADDR |=> {zone2_fan_filter_select, zone1_fan_filter_select,
			zone2_limit_filter_select, zone1_limit_filter_select} == $past(reg_wdata[6:3]))
		else $error("filter selects not written");
	a_sfc1_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
		!(reg_wr && reg_addr == `MSFC_SFC1_ADDR) |=> $stable(st_r.sfc1))
		else $error("first setup register changed without a write");
	a_sfc2_keeps: assert property (@(posedge mclk) disable iff (!rst_n)
		!(reg_wr && reg_addr == `MSFC_SFC2_ADDR) |=> $stable(st_r.sfc2))
		else $error("second setup register changed without a write");
	a_sfc1_res_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == `MSFC_SFC1_ADDR |=> !st_r.sfc1[7])
		else $error("reserved bit of first setup register set");
	a_sfc2_res_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_wr && reg_addr == `MSFC_SFC2_ADDR |=> st_r.sfc2[7:6] == 2'h0)
		else $error("reserved bits of second setup register set");
	a_sfc2_readback: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_rd && reg_addr == `MSFC_SFC2_ADDR |=> reg_rdata == $past({2'h0, zones_c_d_half_degree_select,
			zones_a_b_half_degree_select, tach_smart_mode_enable}))
		else $error("second setup register readback wrong");
	a_unmapped_read: assert property (@(posedge mclk) disable iff (!rst_n)
		reg_rd && reg_addr != `MSFC_SFC1_ADDR && reg_addr != `MSFC_SFC2_ADDR |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (@(posedge mclk) disable iff (!rst_n)
		!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	// temperature sources
	a_zone1_fan_raw: assert property (@(posedge mclk) disable iff (!rst_n)
		!zone1_fan_filter_select && $stable(zone1_fan_filter_select) |=> zone1_fan_temp == $past(zone1_raw_temp))
		else $error("zone 1 fan temperature not raw");
	a_zone2_fan_smooth: assert property (@(posedge mclk) disable iff (!rst_n)
		zone2_fan_filter_select && $stable(zone2_fan_filter_select) |=> zone2_fan_temp == $past(zone2_smooth_temp))
		else $error("zone 2 fan temperature not smoothed");

	// voltage status
	a_err_own_chan: assert property (@(posedge mclk) disable iff (!rst_n)
		volt_valid |=> (volt_err_set & ~(16'h0001 << $past(volt_chan))) == 16'h0000)
		else $error("error raised on a channel not sampled");
	a_out_needs_sample: assert property (@(posedge mclk) disable iff (!rst_n)
		!volt_valid |=> $stable(volt_out_of_limit))
		else $error("limit state changed without a sample");
	a_err_with_out: assert property (@(posedge mclk) disable iff (!rst_n)
		(volt_err_set & ~volt_out_of_limit) == 16'h0000)
		else $error("error raised on a channel in range");

	// reset values
	a_reset_sfc1: assert property (@(posedge mclk)
		!rst_n |=> st_r.sfc1 == `MSFC_SFC1_RESET)
		else $error("first setup register reset value wrong");
	a_reset_sfc2: assert property (@(posedge mclk)
		!rst_n |=> st_r.sfc2 == `MSFC_SFC2_RESET)
		else $error("second setup register reset value wrong");
	a_reset_volt: assert property (@(posedge mclk)
		!rst_n |=> volt_out_of_limit == 16'h0000 && reg_rdata == 8'h00)
		else $error("status not cleared by reset");
endmodule : msfc_top

// file: testbench/tb_msfc_top.sv
/*
 * self-checking bench of the special function setup registers and the logic they steer.
 * assumes msfc_top with one-cycle register strobes and voltage sample strobes on mclk.
 */
`timescale 1ns/1ns
`include "msfc_defines.svh"

module tb_msfc_top
	import msfc_pkg::*;
;
	logic        mclk, rst_n, reg_wr, reg_rd, volt_valid;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, volt_reading, volt_low_limit, volt_high_limit;
	logic [3:0]  volt_chan, tach_smart_mode_enable;
	logic [15:0] volt_out_of_limit, volt_err_set;
	logic [7:0]  zone1_limit_temp, zone2_limit_temp, zone1_fan_temp, zone2_fan_temp;
	logic        zones_a_b_half_degree_select, zones_c_d_half_degree_select;
	logic [7:0]  z1_raw, z1_smooth, z2_raw, z2_smooth;
	logic [5:0]  cfg_bits;
	int          num_errors, cmp_count;

	assign cfg_bits = {zones_c_d_half_degree_select, zones_a_b_half_degree_select, tach_smart_mode_enable};

	msfc_top DUT (
		.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .volt_valid(volt_valid), .volt_chan(volt_chan),
		.volt_reading(volt_reading), .volt_low_limit(volt_low_limit), .volt_high_limit(volt_high_limit),
		.volt_out_of_limit(volt_out_of_limit), .volt_err_set(volt_err_set),
		.zone1_raw_temp(z1_raw), .zone1_smooth_temp(z1_smooth), .zone2_raw_temp(z2_raw), .zone2_smooth_temp(z2_smooth),
		.zone1_limit_temp(zone1_limit_temp), .zone2_limit_temp(zone2_limit_temp),
		.zone1_fan_temp(zone1_fan_temp), .zone2_fan_temp(zone2_fan_temp),
		.tach_smart_mode_enable(tach_smart_mode_enable),
		.zones_a_b_half_degree_select(zones_a_b_half_degree_select),
		.zones_c_d_half_degree_select(zones_c_d_half_degree_select)
	);

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	task automatic tick();
		@(posedge mclk);
		#1;
	endtask : tick

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick();
		reg_wr = 1'b0;
		tick();
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_rd = 1'b1;
		tick();
		reg_rd = 1'b0;
		chk({8'h00, reg_rdata}, {8'h00, e});
		tick();
	endtask : rd

	// write, then read the same place on the very next edge
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		tick();
		reg_wr = 1'b0;
		reg_rd = 1'b1;
		tick();
		reg_rd = 1'b0;
		chk({8'h00, reg_rdata}, {8'h00, e});
		tick();
	endtask : wr_rd

	// one sample, then out and err pulse of that channel one cycle later
	task automatic samp(input logic [3:0] ch, input logic [7:0] r, input logic [7:0] lo, input logic [7:0] hi,
		input logic eo, input logic ee);
		volt_chan = ch;
		volt_reading = r;
		volt_low_limit = lo;
		volt_high_limit = hi;
		volt_valid = 1'b1;
		tick();
		volt_valid = 1'b0;
		chk({14'h0000, volt_out_of_limit[ch], volt_err_set[ch]}, {14'h0000, eo, ee});
		tick();
	endtask : samp

	task automatic print_verdict();
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (5000) @(posedge mclk);
		num_errors++;
		print_verdict();
	end

	initial begin
		logic [3:0] s;
		num_errors = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		{reg_wr, reg_rd, volt_valid} = 3'h0;
		{reg_addr, reg_wdata, volt_reading, volt_low_limit, volt_high_limit} = 40'h0;
		volt_chan = 4'h0;
		{z1_raw, z1_smooth, z2_raw, z2_smooth} = 32'h11213242;
		repeat (8) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		rd(`MSFC_SFC1_ADDR, 8'h00);
		rd(`MSFC_SFC2_ADDR, 8'h00);
		// reserved bits read back zero, unmapped place is ignored
		wr_rd(`MSFC_SFC1_ADDR, 8'hff, 8'h7f);
		wr(`MSFC_SFC2_ADDR, 8'hff);
		wr(8'hbe, 8'h00);
		rd(`MSFC_SFC1_ADDR, 8'h7f);
		rd(`MSFC_SFC2_ADDR, 8'h3f);
		rd(8'hbe, 8'h00);
		// each tach enable and resolution bit alone
		for (int i = 0; i < 6; i++) begin
			// pwm rate and tach binding are set up outside this block
			wr(`MSFC_SFC2_ADDR, 8'h01 << i);
			chk({10'h000, cfg_bits}, 16'h0001 << i);
		end
		// every combination of the four filter selects
		for (int i = 0; i < 16; i++) begin
			s = 4'(i);
			{z1_raw, z1_smooth, z2_raw, z2_smooth} = {4'h1, s, 4'h2, s, 4'h3, s, 4'h4, s};
			// zone smoothing enables live outside and stay clear
			wr(`MSFC_SFC1_ADDR, {1'b0, s, 3'h0});
			tick();
			chk({8'h00, zone1_limit_temp}, {8'h00, s[0] ? z1_smooth : z1_raw});
			chk({8'h00, zone2_limit_temp}, {8'h00, s[1] ? z2_smooth : z2_raw});
			chk({8'h00, zone1_fan_temp}, {8'h00, s[2] ? z1_smooth : z1_raw});
			chk({8'h00, zone2_fan_temp}, {8'h00, s[3] ? z2_smooth : z2_raw});
			// new temperatures show one edge later
			{z1_raw, z1_smooth, z2_raw, z2_smooth} = ~{z1_raw, z1_smooth, z2_raw, z2_smooth};
			tick();
			chk({zone1_fan_temp, zone2_fan_temp}, {s[2] ? z1_smooth : z1_raw, s[3] ? z2_smooth : z2_raw});
		end
		// hysteresis of three counts on high and low sides of two channels
		wr_rd(`MSFC_SFC1_ADDR, 8'h03, 8'h03);
		samp(4'h3, 8'h50, 8'h10, 8'h90, 1'b0, 1'b0);
		samp(4'h3, 8'ha0, 8'h10, 8'h90, 1'b1, 1'b1);
		samp(4'h3, 8'h8e, 8'h10, 8'h90, 1'b1, 1'b1);
		samp(4'h3, 8'h8d, 8'h10, 8'h90, 1'b0, 1'b0);
		samp(4'hc, 8'h0f, 8'h10, 8'h90, 1'b1, 1'b1);
		samp(4'hc, 8'h12, 8'h10, 8'h90, 1'b1, 1'b1);
		samp(4'hc, 8'h13, 8'h10, 8'h90, 1'b0, 1'b0);
		samp(4'h3, 8'ha0, 8'h10, 8'h90, 1'b1, 1'b1);
		// raising the high limit to less than the hysteresis above the reading keeps the channel out
		samp(4'h3, 8'ha0, 8'h10, 8'ha2, 1'b1, 1'b1);
		samp(4'h3, 8'ha0, 8'h10, 8'ha4, 1'b0, 1'b0);
		samp(4'h3, 8'h50, 8'h10, 8'h90, 1'b0, 1'b0);
		samp(4'h3, 8'ha0, 8'h10, 8'h90, 1'b1, 1'b1);
		// masked channel below its low limit stays silent and leaves the out state
		samp(4'h3, 8'h05, 8'h10, 8'hff, 1'b0, 1'b0);
		// zero hysteresis releases at the limit itself
		wr(`MSFC_SFC1_ADDR, 8'h00);
		samp(4'h5, 8'h91, 8'h10, 8'h90, 1'b1, 1'b1);
		samp(4'h5, 8'h90, 8'h10, 8'h90, 1'b0, 1'b0);
		// reset in mid-run clears setup and status
		samp(4'h5, 8'h91, 8'h10, 8'h90, 1'b1, 1'b1);
		wr(`MSFC_SFC1_ADDR, 8'h45);
		rst_n = 1'b0;
		repeat (2) tick();
		rst_n = 1'b1;
		chk(volt_out_of_limit, 16'h0000);
		rd(`MSFC_SFC1_ADDR, 8'h00);
		rd(`MSFC_SFC2_ADDR, 8'h00);
		chk({8'h00, zone2_fan_temp}, {8'h00, z2_raw});
		print_verdict();
	end
endmodule : tb_msfc_top
